// File: rtl/ocpwm_pkg.sv
// Shared constants, types and helpers of the output compare / PWM unit.
// Assumes a 16-bit byte address with 32-bit aligned register words.
package ocpwm_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int NUM_TMR = 4;
  localparam logic [3:0][15:0] TMR_CON_OFF = {16'h0E00, 16'h0C00, 16'h0A00, 16'h0000};
  localparam logic [3:0][15:0] TMR_CNT_OFF = {16'h0E10, 16'h0C10, 16'h0A10, 16'h0810};
  localparam logic [3:0][15:0] TMR_PER_OFF = {16'h0E20, 16'h0C20, 16'h0A20, 16'h0820};
  localparam logic [15:0] OC_CON_OFF = 16'h3000;
  localparam logic [15:0] OC_PRI_OFF = 16'h3010;
  localparam logic [15:0] OC_SEC_OFF = 16'h3020;
  localparam logic [15:0] INT_STS_OFF = 16'h3030;
  localparam logic [15:0] INT_EN_OFF = 16'h3040;
  localparam logic [15:0] INT_CLR_OFF = 16'h3050;

  // ---------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [15:0] TMR_CON_RST = 16'h0000;
  localparam logic [15:0] TMR_PER_RST = 16'hFFFF;
  localparam logic [15:0] TMR_CON_MASK_EVEN = 16'hA0FA;
  localparam logic [15:0] TMR_CON_MASK_ODD = 16'hA0F2;
  localparam logic [15:0] OC_CON_MASK = 16'hA02F;
  localparam logic [31:0] MASK_NARROW = 32'h0000FFFF;
  localparam logic [31:0] MASK_WIDE = 32'hFFFFFFFF;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TC_ON = 15;
  localparam int TC_IDLE = 13;
  localparam int TC_PS_LO = 4;
  localparam int TC_PAIR = 3;
  localparam int TC_EXT = 1;
  localparam int OC_ON = 15;
  localparam int OC_IDLE = 13;
  localparam int OC_WIDE = 5;
  localparam int OC_FLT = 4;
  localparam int OC_TSEL = 3;
  localparam int ST_CMP = 0;
  localparam int ST_FLT = 1;
  localparam int ST_TMR_LO = 2;
  localparam int NUM_STS = 6;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF, MODE_SET_HIGH, MODE_FORCE_LOW, MODE_TOGGLE,
    MODE_ONE_PULSE, MODE_PULSE_TRAIN, MODE_PWM_NOFAULT, MODE_PWM_FAULT
  } ocpwm_mode_type;

  typedef enum logic [1:0] {OP_WRITE, OP_CLR, OP_SET, OP_INV} ocpwm_op_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ocpwm_bus_req_type;

  // Write, clear, set or invert a register word
  function automatic logic [31:0] apply_op(ocpwm_op_type op, logic [31:0] cur,
                                           logic [31:0] wd);
    unique case (op)
      OP_WRITE: apply_op = wd;
      OP_CLR: apply_op = cur & ~wd;
      OP_SET: apply_op = cur | wd;
      OP_INV: apply_op = cur ^ wd;
    endcase
  endfunction : apply_op

  // Prescale divisor minus one
  function automatic logic [7:0] prescale_max(logic [2:0] sel);
    unique case (sel)
      3'h0: prescale_max = 8'h00;
      3'h1: prescale_max = 8'h01;
      3'h2: prescale_max = 8'h03;
      3'h3: prescale_max = 8'h07;
      3'h4: prescale_max = 8'h0F;
      3'h5: prescale_max = 8'h1F;
      3'h6: prescale_max = 8'h3F;
      3'h7: prescale_max = 8'hFF;
    endcase
  endfunction : prescale_max

endpackage : ocpwm_pkg

// File: rtl/ocpwm_timer.sv
// One general-purpose timer: prescaler, up counter, period reload.
// Assumes its controls come from the register file of the compare unit.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic use_ext,
  input wire logic ext_tick,
  input wire logic [2:0] prescale_select,
  input wire logic wide,
  input wire logic [31:0] period,
  input wire logic load,
  input wire logic [31:0] load_val,
  output logic [31:0] count,
  output logic roll
);

  typedef struct packed {
    logic [7:0] pre;
    logic [31:0] cnt;
    logic roll;
  } ocpwm_tmr_state_type;

  ocpwm_tmr_state_type state_ff;
  ocpwm_tmr_state_type nxt_state;
  logic [31:0] mask;
  logic tick;

  // -------------------------------------------------------------
  // Count logic
  // -------------------------------------------------------------
  assign mask = wide ? ocpwm_pkg::MASK_WIDE : ocpwm_pkg::MASK_NARROW;
  assign tick = use_ext ? ext_tick : 1'b1;

  // Prescale, count up, wrap at the period
  always_comb begin
    nxt_state = state_ff;
    nxt_state.roll = 1'b0;
    if (load) begin
      nxt_state.cnt = load_val & mask;
      nxt_state.pre = 8'h00;
    end else if (run && tick) begin
      if (state_ff.pre >= ocpwm_pkg::prescale_max(prescale_select)) begin
        nxt_state.pre = 8'h00;
        if ((state_ff.cnt & mask) == (period & mask)) begin
          nxt_state.cnt = 32'h00000000;
          nxt_state.roll = 1'b1;
        end else begin
          nxt_state.cnt = (state_ff.cnt + 32'h00000001) & mask;
        end
      end else begin
        nxt_state.pre = state_ff.pre + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign count = state_ff.cnt;
  assign roll = state_ff.roll;

endmodule : ocpwm_timer
`default_nettype wire

// File: rtl/ocpwm_unit.sv
// Output compare / PWM unit with four general-purpose timers and registers.
// Assumes a single-cycle register port and synchronous inputs on clk.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_unit (
  input wire logic clk,
  input wire logic nrst,
  input wire ocpwm_pkg::ocpwm_bus_req_type bus_req,
  output logic [31:0] bus_rdata,
  input wire logic cpu_idle,
  input wire logic [3:0] timer_ext_tick,
  input wire logic pwm_fault_in,
  output logic compare_output_pin,
  output logic irq
);

  // -------------------------------------------------------------
  // State and signals
  // -------------------------------------------------------------
  // All state except the timer counters in one struct, registered by a single process
  typedef struct packed {
    logic [3:0][15:0] tcon;
    logic [3:0][15:0] tper;
    logic [15:0] ocon;
    logic [31:0] pri;
    logic [31:0] sec;
    logic [31:0] duty;
    logic fault;
    logic [5:0] sts;
    logic [5:0] ien;
    logic [31:0] rdata;
    logic out;
    logic prev_match;
    logic prev_end;
    logic pulse_done;
    logic [2:0] mode_prev;
    logic on_prev;
  } ocpwm_state_type;

  ocpwm_state_type state_ff;
  ocpwm_state_type nxt_state;

  logic [3:0][31:0] tcount;
  logic [3:0] troll;
  logic [3:0] trun;
  logic [3:0] tload;
  logic [3:0][31:0] tload_val;
  logic [3:0][31:0] tperiod;
  logic [3:0] twide;
  logic [15:0] base;
  ocpwm_pkg::ocpwm_op_type op;
  ocpwm_pkg::ocpwm_mode_type mode;
  logic oc_on;
  logic oc_run;
  logic oc_wide;
  logic [31:0] cmp_mask;
  logic [31:0] cmp_cnt;
  logic cmp_roll;
  logic match_evt;
  logic end_evt;
  logic fault_evt;
  logic cmp_evt;

  // -------------------------------------------------------------
  // Timers
  // -------------------------------------------------------------
  // Pairing: an even timer with its pair bit set counts 32 bits
  genvar gi;
  generate
    for (gi = 0; gi < ocpwm_pkg::NUM_TMR; gi++) begin : g_tmr
      if (gi % 2 == 0) begin : g_even
        assign twide[gi] = state_ff.tcon[gi][ocpwm_pkg::TC_PAIR];
        // Paired period: odd half above, even half below
        assign tperiod[gi] = twide[gi] ? {state_ff.tper[gi + 1], state_ff.tper[gi]}
                                       : {16'h0000, state_ff.tper[gi]};
        assign trun[gi] = state_ff.tcon[gi][ocpwm_pkg::TC_ON] &
                          ~(state_ff.tcon[gi][ocpwm_pkg::TC_IDLE] & cpu_idle);
      end else begin : g_odd
        assign twide[gi] = 1'b0;
        assign tperiod[gi] = {16'h0000, state_ff.tper[gi]};
        // Halted while absorbed into the 32-bit pair
        assign trun[gi] = state_ff.tcon[gi][ocpwm_pkg::TC_ON] &
                          ~(state_ff.tcon[gi][ocpwm_pkg::TC_IDLE] & cpu_idle) &
                          ~state_ff.tcon[gi - 1][ocpwm_pkg::TC_PAIR];
      end
      // One timer per slot; odd slots never pair themselves
      ocpwm_timer u_timer (
        .clk(clk),
        .nrst(nrst),
        .run(trun[gi]),
        .use_ext(state_ff.tcon[gi][ocpwm_pkg::TC_EXT]),
        .ext_tick(timer_ext_tick[gi]),
        .prescale_select(state_ff.tcon[gi][ocpwm_pkg::TC_PS_LO +: 3]),
        .wide(twide[gi]),
        .period(tperiod[gi]),
        .load(tload[gi]),
        .load_val(tload_val[gi]),
        .count(tcount[gi]),
        .roll(troll[gi])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // Compare source selection
  // -------------------------------------------------------------
  // Control fields of the compare unit
  assign mode = ocpwm_pkg::ocpwm_mode_type'(state_ff.ocon[2:0]);
  assign oc_on = state_ff.ocon[ocpwm_pkg::OC_ON];
  assign oc_run = oc_on & ~(state_ff.ocon[ocpwm_pkg::OC_IDLE] & cpu_idle);
  assign oc_wide = state_ff.ocon[ocpwm_pkg::OC_WIDE];
  assign cmp_mask = oc_wide ? ocpwm_pkg::MASK_WIDE : ocpwm_pkg::MASK_NARROW;

  // Wide compare uses the paired 32-bit count, else the selected timer
  always_comb begin
    if (oc_wide) begin
      cmp_cnt = tcount[0];
      cmp_roll = troll[0];
    end else if (state_ff.ocon[ocpwm_pkg::OC_TSEL]) begin
      cmp_cnt = tcount[1] & ocpwm_pkg::MASK_NARROW;
      cmp_roll = troll[1];
    end else begin
      cmp_cnt = tcount[0] & ocpwm_pkg::MASK_NARROW;
      cmp_roll = troll[0];
    end
  end

  // -------------------------------------------------------------
  // Compare events
  // -------------------------------------------------------------
  // Match events fire on the first cycle of equality
  // A parked count must not fire again every cycle
  assign match_evt = oc_run & (cmp_cnt == (state_ff.pri & cmp_mask)) &
                     ~state_ff.prev_match;
  assign end_evt = oc_run & (cmp_cnt == (state_ff.sec & cmp_mask)) &
                   ~state_ff.prev_end;
  assign fault_evt = oc_run & (mode == ocpwm_pkg::MODE_PWM_FAULT) & pwm_fault_in &
                     ~state_ff.fault;
  assign cmp_evt = match_evt & (mode != ocpwm_pkg::MODE_OFF);

  // -------------------------------------------------------------
  // Register decode and next state
  // -------------------------------------------------------------
  // Word address and alias selector
  assign base = {bus_req.addr[15:4], 4'h0};
  assign op = ocpwm_pkg::ocpwm_op_type'(bus_req.addr[3:2]);

  always_comb begin
    logic [31:0] cur;
    logic [31:0] nv;
    logic [15:0] cmask;
    logic [5:0] clr;
    cur = 32'h00000000;
    nv = 32'h00000000;
    cmask = 16'h0000;
    clr = 6'h00;
    nxt_state = state_ff;
    nxt_state.rdata = 32'h00000000;
    tload = 4'h0;
    tload_val = '0;

    // Timer registers, each with clear/set/invert aliases
    for (int i = 0; i < ocpwm_pkg::NUM_TMR; i++) begin
      cmask = (i % 2 == 0) ? ocpwm_pkg::TMR_CON_MASK_EVEN : ocpwm_pkg::TMR_CON_MASK_ODD;
      // Control write keeps only implemented bits
      if (base == ocpwm_pkg::TMR_CON_OFF[i]) begin
        cur = {16'h0000, state_ff.tcon[i]};
        nv = ocpwm_pkg::apply_op(op, cur, bus_req.wdata);
        if (bus_req.wr) nxt_state.tcon[i] = nv[15:0] & cmask;
      end

      // Period is a plain 16-bit word
      if (base == ocpwm_pkg::TMR_PER_OFF[i]) begin
        cur = {16'h0000, state_ff.tper[i]};
        nv = ocpwm_pkg::apply_op(op, cur, bus_req.wdata);
        if (bus_req.wr) nxt_state.tper[i] = nv[15:0];
      end

      // Count write reloads the timer and clears its prescaler
      if (base == ocpwm_pkg::TMR_CNT_OFF[i]) begin
        if (i % 2 == 1 && state_ff.tcon[i - 1][ocpwm_pkg::TC_PAIR]) begin
          cur = {16'h0000, tcount[i - 1][31:16]};
        end else begin
          cur = twide[i] ? tcount[i] : (tcount[i] & ocpwm_pkg::MASK_NARROW);
        end
        nv = ocpwm_pkg::apply_op(op, cur, bus_req.wdata);
        tload[i] = bus_req.wr;
        tload_val[i] = nv;
      end
    end

    // Compare unit registers, aliases as for the timers
    if (base == ocpwm_pkg::OC_CON_OFF) begin
      cur = {16'h0000, state_ff.ocon};
      cur[ocpwm_pkg::OC_FLT] = state_ff.fault & (mode == ocpwm_pkg::MODE_PWM_FAULT);
      nv = ocpwm_pkg::apply_op(op, cur, bus_req.wdata);
      if (bus_req.wr) nxt_state.ocon = nv[15:0] & ocpwm_pkg::OC_CON_MASK;
    end

    if (base == ocpwm_pkg::OC_PRI_OFF) begin
      cur = state_ff.pri;
      nv = ocpwm_pkg::apply_op(op, cur, bus_req.wdata);
      if (bus_req.wr) nxt_state.pri = nv;
    end

    if (base == ocpwm_pkg::OC_SEC_OFF) begin
      cur = state_ff.sec;
      nv = ocpwm_pkg::apply_op(op, cur, bus_req.wdata);
      if (bus_req.wr) nxt_state.sec = nv;
    end

    // Status word is read-only
    if (base == ocpwm_pkg::INT_STS_OFF) begin
      cur = {26'h0000000, state_ff.sts};
    end

    if (base == ocpwm_pkg::INT_EN_OFF) begin
      cur = {26'h0000000, state_ff.ien};
      nv = ocpwm_pkg::apply_op(op, cur, bus_req.wdata);
      if (bus_req.wr) nxt_state.ien = nv[5:0];
    end

    // Clear word is write-only, with no aliases
    if (bus_req.addr == ocpwm_pkg::INT_CLR_OFF && bus_req.wr) begin
      clr = bus_req.wdata[5:0];
    end

    // Alias and clear words read as zero
    // Read data only for base addresses, one cycle later
    if (bus_req.rd && op == ocpwm_pkg::OP_WRITE) begin
      nxt_state.rdata = cur;
    end

    // Compare output sequencing
    // Equality tracked only while running, so a halt makes no edge
    nxt_state.prev_match = oc_run ? (cmp_cnt == (state_ff.pri & cmp_mask))
                                  : state_ff.prev_match;
    nxt_state.prev_end = oc_run ? (cmp_cnt == (state_ff.sec & cmp_mask))
                                : state_ff.prev_end;
    // Off: pin low, sequencing and fault cleared
    if (!oc_on) begin
      nxt_state.out = 1'b0;
      nxt_state.pulse_done = 1'b0;
      nxt_state.fault = 1'b0;
      nxt_state.on_prev = 1'b0;
    end else if (oc_run) begin
      // Remember what ran, to spot a new mode
      nxt_state.on_prev = 1'b1;
      nxt_state.mode_prev = state_ff.ocon[2:0];
      if (!state_ff.on_prev || state_ff.mode_prev != state_ff.ocon[2:0]) begin
        // Initial level on entering a mode
        nxt_state.out = (mode == ocpwm_pkg::MODE_FORCE_LOW);
        nxt_state.pulse_done = 1'b0;
        nxt_state.fault = 1'b0;
        nxt_state.duty = state_ff.sec;
      end else begin
        // Steady running: one action per mode
        unique case (mode)
          ocpwm_pkg::MODE_OFF: nxt_state.out = 1'b0;
          ocpwm_pkg::MODE_SET_HIGH: if (match_evt) nxt_state.out = 1'b1;
          ocpwm_pkg::MODE_FORCE_LOW: if (match_evt) nxt_state.out = 1'b0;
          ocpwm_pkg::MODE_TOGGLE: if (match_evt) nxt_state.out = ~state_ff.out;
          ocpwm_pkg::MODE_ONE_PULSE, ocpwm_pkg::MODE_PULSE_TRAIN: begin
            if (!state_ff.pulse_done) begin
              if (match_evt) begin
                nxt_state.out = 1'b1;
              end else if (end_evt && state_ff.out) begin
                nxt_state.out = 1'b0;
                nxt_state.pulse_done = (mode == ocpwm_pkg::MODE_ONE_PULSE);
              end
            end
          end
          ocpwm_pkg::MODE_PWM_NOFAULT, ocpwm_pkg::MODE_PWM_FAULT: begin
            // New duty latched at each period start
            if (cmp_roll) begin
              nxt_state.duty = state_ff.sec;
              nxt_state.out = ((state_ff.sec & cmp_mask) != 32'h00000000);
              if (!pwm_fault_in) nxt_state.fault = 1'b0;
            end else if (cmp_cnt == (state_ff.duty & cmp_mask)) begin
              nxt_state.out = 1'b0;
            end
            // Fault holds the pin low until a clean period start
            if (mode == ocpwm_pkg::MODE_PWM_FAULT && (pwm_fault_in || nxt_state.fault)) begin
              nxt_state.out = 1'b0;
              nxt_state.fault = 1'b1;
            end
          end
        endcase
      end
    end

    // Sticky event flags, set wins over clear
    nxt_state.sts = state_ff.sts & ~clr;
    if (cmp_evt) nxt_state.sts[ocpwm_pkg::ST_CMP] = 1'b1;
    if (fault_evt) nxt_state.sts[ocpwm_pkg::ST_FLT] = 1'b1;
    // Timer rolls feed status bits two and up
    for (int i = 0; i < ocpwm_pkg::NUM_TMR; i++) begin
      if (troll[i]) nxt_state.sts[ocpwm_pkg::ST_TMR_LO + i] = 1'b1;
    end
  end

  // -------------------------------------------------------------
  // State register
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Periods reset to all ones, the rest to zero
      state_ff <= '0;
      state_ff.tper <= {4{ocpwm_pkg::TMR_PER_RST}};
      state_ff.tcon <= {4{ocpwm_pkg::TMR_CON_RST}};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  // Data outputs straight from flip-flops; irq is a plain level
  assign bus_rdata = state_ff.rdata;
  assign compare_output_pin = state_ff.out;
  assign irq = |(state_ff.sts & state_ff.ien);

endmodule : ocpwm_unit
`default_nettype wire

// File: tb/ocpwm_load.sv
// Load on the compare output: counts pulses and the width of the last one.
// Assumes the pin is registered on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_load (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  input wire logic clear,
  output var int rises,
  output var int width
);
  logic prev;
  int run;
  // Rising edges and high time in clock cycles
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev <= 1'b0;
      run <= 0;
      rises <= 0;
      width <= 0;
    end else begin
      prev <= pin;
      if (clear) begin
        rises <= 0;
      end else if (pin && !prev) begin
        rises <= rises + 1;
      end
      if (pin && !prev) begin
        run <= 1;
      end else if (pin) begin
        run <= run + 1;
      end
      if (!pin && prev) begin
        width <= run;
      end
    end
  end
endmodule : ocpwm_load
`default_nettype wire

// File: tb/ocpwm_unit_properties.sv
// Port-level checks of the compare unit, with a shadow of its control word.
// Assumes one clock domain and the single-cycle register port.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_unit_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire ocpwm_pkg::ocpwm_bus_req_type bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic cpu_idle,
  input wire logic [3:0] timer_ext_tick,
  input wire logic pwm_fault_in,
  input wire logic compare_output_pin,
  input wire logic irq
);
  localparam logic [15:0] CON_A = ocpwm_pkg::OC_CON_OFF;
  localparam logic [15:0] IEN_A = ocpwm_pkg::INT_EN_OFF;
  logic [15:0] con_ff;
  logic [15:0] nxt_con;
  logic con_rd;
  // ------
  // Shadow of the control word
  // ------
  always_comb begin
    nxt_con = con_ff;
    if (bus_req.wr && bus_req.addr[15:4] == CON_A[15:4]) begin
      case (bus_req.addr[3:2])
        2'h0: nxt_con = bus_req.wdata[15:0];
        2'h1: nxt_con = con_ff & ~bus_req.wdata[15:0];
        2'h2: nxt_con = con_ff | bus_req.wdata[15:0];
        default: nxt_con = con_ff ^ bus_req.wdata[15:0];
      endcase
    end
  end
  // Register the shadow
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      con_ff <= 16'h0000;
    end else begin
      con_ff <= nxt_con;
    end
  end
  assign con_rd = bus_req.rd && bus_req.addr == CON_A;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ------
  // Assertions
  // ------
  a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_alias_read_zero: assert property (
    $past(bus_req.rd) && $past(bus_req.addr[3:2]) != 2'h0 |-> bus_rdata == 32'h0)
    else $error("alias read not zero");
  a_unimpl_bits_zero: assert property ($past(con_rd) |-> (bus_rdata & 32'hFFFF5FC0) == 32'h0)
    else $error("unused control bits not zero");
  a_con_readback: assert property ($past(con_rd) |->
    {bus_rdata[15], bus_rdata[13], bus_rdata[5], bus_rdata[3:0]} ==
    $past({con_ff[15], con_ff[13], con_ff[5], con_ff[3:0]}))
    else $error("control readback differs");
  a_fault_mode_zero: assert property ($past(con_rd) && bus_rdata[2:0] != 3'h7 |-> !bus_rdata[4])
    else $error("fault status set outside fault mode");
  a_off_pin_low: assert property (!con_ff[15] [*3] |-> !compare_output_pin)
    else $error("pin high while unit off");
  a_mode_idle_low: assert property (con_ff[2:0] == 3'h0 [*3] |-> !compare_output_pin)
    else $error("pin high in mode zero");
  a_fault_pin_low: assert property (
    (con_ff[15] && con_ff[2:0] == 3'h7 && pwm_fault_in) [*4] |-> !compare_output_pin)
    else $error("pin high during fault");
  a_irq_masked_off: assert property (
    bus_req.wr && bus_req.addr == IEN_A && bus_req.wdata == 32'h0 |=> !irq)
    else $error("interrupt high with all enables off");
  a_idle_pin_hold: assert property (
    (con_ff[15] && con_ff[13] && cpu_idle) [*3] |-> $stable(compare_output_pin))
    else $error("pin moved while halted in idle");
  c_fault_seen: cover property (con_ff[2:0] == 3'h7 && con_ff[15] && pwm_fault_in);
  c_idle_halt: cover property (con_ff[13] && con_ff[15] && cpu_idle);
  c_irq_rise: cover property ($rose(irq));
endmodule : ocpwm_unit_properties
bind ocpwm_unit ocpwm_unit_properties chk (
  .clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .cpu_idle(cpu_idle), .timer_ext_tick(timer_ext_tick),
  .pwm_fault_in(pwm_fault_in), .compare_output_pin(compare_output_pin), .irq(irq));
`default_nettype wire

// File: tb/ocpwm_unit_test.sv
// Self-checking bench: register tasks, then one scenario per output mode.
// Assumes the checker is bound to the unit and a load watches the pin.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_unit_test;
  localparam logic [15:0] CON = ocpwm_pkg::OC_CON_OFF;
  localparam logic [15:0] PRI = ocpwm_pkg::OC_PRI_OFF;
  localparam logic [15:0] SEC = ocpwm_pkg::OC_SEC_OFF;
  localparam logic [15:0] STS = ocpwm_pkg::INT_STS_OFF;
  localparam logic [15:0] IEN = ocpwm_pkg::INT_EN_OFF;
  localparam logic [15:0] ICL = ocpwm_pkg::INT_CLR_OFF;
  localparam logic [15:0] T2C = ocpwm_pkg::TMR_CON_OFF[0];
  localparam logic [15:0] T2N = ocpwm_pkg::TMR_CNT_OFF[0];
  localparam logic [15:0] T2P = ocpwm_pkg::TMR_PER_OFF[0];
  localparam logic [15:0] T3C = ocpwm_pkg::TMR_CON_OFF[1];
  localparam logic [15:0] T3P = ocpwm_pkg::TMR_PER_OFF[1];
  logic clk;
  logic nrst;
  ocpwm_pkg::ocpwm_bus_req_type bus_req;
  logic [31:0] bus_rdata;
  logic cpu_idle;
  logic [3:0] timer_ext_tick;
  logic pwm_fault_in;
  logic pin;
  logic irq;
  logic load_clear;
  logic [31:0] rv;
  int rises;
  int width;
  int err_count;
  int checked;
  int m;
  ocpwm_unit uut (.clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cpu_idle(cpu_idle), .timer_ext_tick(timer_ext_tick), .pwm_fault_in(pwm_fault_in),
    .compare_output_pin(pin), .irq(irq));
  ocpwm_load load (.clk(clk), .nrst(nrst), .pin(pin), .clear(load_clear),
    .rises(rises), .width(width));
  // Clock
  always #10 clk = ~clk;
  // ------
  // Tasks
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    rv = bus_rdata;
  endtask : rd
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    rd(a);
    check(rv, e);
  endtask : rdchk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_pin(input logic lvl, input int lim);
    for (int i = 0; i < lim && pin !== lvl; i++) begin
      cyc(1);
    end
    check(pin, lvl);
    if (pin !== lvl) complete_run();
  endtask : wait_pin
  task automatic off();
    wr(CON, 32'h0);
    cyc(1);
    wr(ICL, 32'h0000003F);
    load_clear <= 1'b1;
    cyc(1);
    load_clear <= 1'b0;
  endtask : off
  // ------
  // Main sequence
  // ------
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    bus_req = '0;
    cpu_idle = 1'b0;
    timer_ext_tick = 4'h0;
    pwm_fault_in = 1'b0;
    load_clear = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    #1;
    rdchk(CON, 32'h0);
    rdchk(T2P, 32'h0000FFFF);
    rdchk(16'h2000, 32'h0);
    wr(CON, 32'hFFFFFFFF);
    rdchk(CON, 32'h0000A02F);
    off();
    wr(T2P, 32'h1234);
    wr(T2P + 16'h8, 32'hF0);
    rdchk(T2P, 32'h12F4);
    wr(T2P + 16'h4, 32'h4);
    rdchk(T2P, 32'h12F0);
    wr(T2P + 16'hC, 32'hF);
    rdchk(T2P, 32'h12FF);
    rdchk(T2P + 16'h8, 32'h0);
    wr(T2P, 32'd19);
    wr(T3P, 32'd9);
    wr(PRI, 32'd5);
    wr(SEC, 32'd10);
    wr(IEN, 32'h1);
    wr(T2C, 32'h8000);
    // Set and force-low on a match
    for (m = 1; m < 3; m++) begin
      wr(CON, 32'h8000 | m);
      wait_pin(m == 2, 4);
      wait_pin(m == 1, 30);
      cyc(1);
      check(irq, 1'b1);
      off();
      check(irq, 1'b0);
    end
    // Toggle, pulse train, single pulse, mode zero
    wr(CON, 32'h8003);
    wait_pin(1'b1, 30);
    wait_pin(1'b0, 25);
    wait_pin(1'b1, 25);
    wait_pin(1'b0, 25);
    // Load posts the width one edge after the fall
    cyc(1);
    check(width, 32'd20);
    off();
    wr(CON, 32'h8005);
    repeat (2) begin
      wait_pin(1'b1, 30);
      wait_pin(1'b0, 10);
    end
    cyc(1);
    check(width, 32'd5);
    off();
    wr(CON, 32'h8004);
    cyc(90);
    check(rises, 32'd1);
    check(width, 32'd5);
    off();
    wr(CON, 32'h8000);
    cyc(45);
    check(rises, 32'd0);
    rd(STS);
    check(rv[0], 1'b0);
    off();
    // PWM with the fault input ignored, then honoured
    wr(SEC, 32'd8);
    pwm_fault_in <= 1'b1;
    wr(CON, 32'h8006);
    wait_pin(1'b1, 30);
    wait_pin(1'b0, 12);
    cyc(1);
    check(width, 32'd8);
    pwm_fault_in <= 1'b0;
    wr(SEC, 32'd16);
    wr(CON, 32'h8007);
    wait_pin(1'b1, 30);
    pwm_fault_in <= 1'b1;
    wait_pin(1'b0, 4);
    rd(CON);
    check(rv[4], 1'b1);
    wr(CON + 16'h4, 32'h10);
    rd(CON);
    check(rv[4], 1'b1);
    rd(STS);
    check(rv[1], 1'b1);
    wr(CON + 16'h4, 32'h1);
    rdchk(CON, 32'h8006);
    pwm_fault_in <= 1'b0;
    off();
    // Timebase choice, then wide compare
    wr(T2C, 32'h0);
    wr(T2N, 32'h0);
    wr(T3C, 32'h8000);
    wr(CON, 32'h8009);
    wait_pin(1'b1, 20);
    off();
    wr(T3C, 32'h0);
    wr(CON, 32'h8001);
    cyc(45);
    check(pin, 1'b0);
    off();
    wr(T2C, 32'h8000);
    wr(PRI, 32'h00010005);
    wr(CON, 32'h8021);
    cyc(45);
    check(pin, 1'b0);
    off();
    wr(CON, 32'h8001);
    wait_pin(1'b1, 30);
    off();
    // Idle halt, disable, interrupt mask and clear
    cpu_idle <= 1'b1;
    wr(CON, 32'hA001);
    cyc(45);
    check(pin, 1'b0);
    cpu_idle <= 1'b0;
    wait_pin(1'b1, 30);
    wr(CON, 32'h0001);
    wait_pin(1'b0, 4);
    cyc(1);
    wr(IEN, 32'h0);
    check(irq, 1'b0);
    wr(IEN, 32'h1);
    check(irq, 1'b1);
    wr(ICL, 32'h1);
    check(irq, 1'b0);
    complete_run();
  end
endmodule : ocpwm_unit_test
`default_nettype wire
